/* File: bench/epwc_ctrl_bench.sv */
`default_nettype none
module epwc_ctrl_bench
   import epwc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int          PCYC = 20;
   localparam int          SCYC = 4;
   localparam logic [31:0] LAN  = 32'h0000_0200;
   localparam logic [31:0] NRG  = 32'h0000_0100;
   localparam logic [31:0] DRV  = 32'h0000_0040;
   localparam logic [31:0] PUL  = 32'h0000_0008;
   localparam logic [31:0] POL  = 32'h0000_0004;
   localparam logic [31:0] PEN  = 32'h0000_0002;
   logic          pclk = 1'b0;
   logic          presetn = 1'b0;
   epwc_apb_req_t req = '0;
   epwc_apb_rsp_t rsp;
   logic          lan = 1'b0;
   logic          nrg = 1'b0;
   epwc_pin_t     pin;
   logic          irq;
   logic          xrst;
   logic          alive;
   logic [1:0]    psf;
   int            n_errors = 0;
   int            total_checks = 0;
   int            cycles = 0;
   logic [31:0]   rd_q;
   logic          err_q;

   always #12.5 pclk = ~pclk;

   epwc_ctrl #(.PULSE_CYCLES(PCYC), .SETTLE_CYCLES(SCYC)) i_epwc_ctrl (
      .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
      .lan_wake_src(lan), .energy_wake_src(nrg), .wake_event_output(pin),
      .wake_event_interrupt(irq), .transceiver_reset(xrst),
      .power_state_field(psf), .device_alive(alive));

   task automatic stop_test();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : stop_test

   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         $display("[FAIL] %0t timeout", $time);
         stop_test();
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check

   // one apb transfer, held until pready is sampled high
   task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge pclk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge pclk);
      req.penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (rsp.pready !== 1'b1);
      rd_q = rsp.prdata;
      err_q = rsp.pslverr;
      req <= '0;
   endtask : xfer

   task automatic wait_alive();
      int k;
      k = 0;
      while (alive !== 1'b1 && k < 100) begin
         @(posedge pclk);
         k++;
      end
      check(32'(alive), 32'h1, "device alive");
   endtask : wait_alive

   task automatic t_reset();
      check({29'h0, alive, psf}, 32'h0, "reset outputs");
      wait_alive();
      xfer(1'b1, OFS_PWR_CTRL, LAN | PEN);
      xfer(1'b0, OFS_PWR_CTRL, WORD_ZERO);
      check(rd_q, 32'h1, "write before read");
      xfer(1'b0, 12'h004, WORD_ZERO);
      check(32'(err_q), 32'h1, "unmapped read");
   endtask : t_reset

   task automatic t_level();
      logic [31:0] c;
      c = LAN | NRG | DRV | POL | PEN;
      xfer(1'b1, OFS_PWR_CTRL, c);
      lan <= 1'b1;
      repeat (30) @(posedge pclk);
      check({30'h0, irq, pin.out & pin.oe}, 32'h3, "lan wake level");
      xfer(1'b0, OFS_PWR_CTRL, WORD_ZERO);
      check(rd_q, c | 32'h21, "cause lan");
      nrg <= 1'b1;
      repeat (3) @(posedge pclk);
      xfer(1'b0, OFS_PWR_CTRL, WORD_ZERO);
      check(rd_q, c | 32'h31, "cause both");
      xfer(1'b1, OFS_PWR_CTRL, c | 32'h30);
      xfer(1'b0, OFS_PWR_CTRL, WORD_ZERO);
      check(rd_q, c | 32'h31, "clear with source high");
      lan <= 1'b0;
      nrg <= 1'b0;
      xfer(1'b1, OFS_PWR_CTRL, c | 32'h20);
      xfer(1'b0, OFS_PWR_CTRL, WORD_ZERO);
      check(rd_q, c | 32'h11, "clear lan only");
      check({30'h0, irq, pin.out & pin.oe}, 32'h3, "energy wake level");
      xfer(1'b1, OFS_PWR_CTRL, c | 32'h10);
      repeat (3) @(posedge pclk);
      check({30'h0, irq, pin.out}, 32'h0, "released");
   endtask : t_level

   task automatic t_pulse();
      xfer(1'b1, OFS_PWR_CTRL, LAN | DRV | PUL | PEN);
      lan <= 1'b1;
      repeat (3) @(posedge pclk);
      check({30'h0, pin.oe, pin.out}, 32'h2, "active low pulse");
      repeat (PCYC + 5) @(posedge pclk);
      check(32'(pin.out), 32'h1, "pulse ended");
      lan <= 1'b0;
      xfer(1'b1, OFS_PWR_CTRL, LAN | PEN | 32'h20);
      lan <= 1'b1;
      repeat (3) @(posedge pclk);
      check({30'h0, pin.oe, pin.out}, 32'h2, "open drain");
      xfer(1'b1, OFS_PWR_CTRL, LAN);
      repeat (2) @(posedge pclk);
      check({30'h0, irq, pin.oe}, 32'h2, "pin off irq on");
      lan <= 1'b0;
      xfer(1'b1, OFS_PWR_CTRL, 32'h20);
   endtask : t_pulse

   task automatic t_xrst();
      int t0;
      int k;
      xfer(1'b1, OFS_PWR_CTRL, 32'h400);
      t0 = cycles;
      xfer(1'b0, OFS_PWR_CTRL, WORD_ZERO);
      check(32'(rd_q[XRST_BIT] & xrst), 32'h1, "xrst high");
      xfer(1'b1, OFS_PWR_CTRL, 32'h400);
      k = 0;
      while (xrst !== 1'b0 && k < 5000) begin
         @(posedge pclk);
         k++;
      end
      k = cycles - t0;
      check(32'(k >= XRST_CYC && k <= XRST_CYC + 3), 32'h1, "xrst length");
   endtask : t_xrst

   task automatic t_power();
      logic [1:0] m;
      for (int i = 0; i < 2; i++) begin
         m = (i == 0) ? MODE_FRAME : MODE_ENERGY;
         xfer(1'b1, OFS_PWR_CTRL, {18'h0, m, 12'h0});
         repeat (3) @(posedge pclk);
         check(32'(psf), 32'(m), "state field");
         xfer(1'b0, OFS_PWR_CTRL, WORD_ZERO);
         check(32'(rd_q[MODE_MSB:MODE_LSB]), 32'(m), "ctrl readable");
         xfer(1'b1, OFS_BYTE_TEST, 32'h0000_00A5);
         wait_alive();
         check(32'(psf), 32'h0, "woken");
         xfer(1'b1, OFS_PWR_CTRL, PEN);
         xfer(1'b0, OFS_PWR_CTRL, WORD_ZERO);
         check(rd_q, 32'h1, "write before read after wake");
      end
      xfer(1'b1, OFS_PWR_CTRL, 32'h3000);
      repeat (3) @(posedge pclk);
      check(32'(psf), 32'h0, "mode 11 refused");
   endtask : t_power

   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_level();
      t_pulse();
      t_xrst();
      t_power();
      stop_test();
   end
endmodule : epwc_ctrl_bench
`default_nettype wire

/* File: core/epwc_ctrl.sv */
// How it works
// - power state field: 00 full, 01 frame wake, 10 energy wake, 11 not allowed
// - any byte test write in a reduced state returns the device to full operation
// - writes are ignored until one read completes after reset or wake
// - the power control register stays readable in every power state
// - writing one resets the transceiver for at least 100us, then self-clears
// - writes to the transceiver reset bit are ignored while it reads high
// - lan wake with pin enabled drives the wake pin per pulse select
// - lan wake raises the internal wake interrupt whatever the pin enable
// - energy wake with pin enabled drives the wake pin per pulse select
// - energy wake raises the internal wake interrupt whatever the pin enable
// - driver type clear: open drain active low; set: push-pull
// - wake cause: 00 none, 01 energy, 10 frame or packet, 11 both
// - a wake cause bit clears by writing one; zero leaves it
// - wake cause bits clear only in full operation with device alive
// - a wake cause bit clears only once its event source is gone
// - pulse select: 50ms pulse; else level until cause or enable clears
// - polarity set: push-pull pin active high, else active low
// - pin enable gates only the pin, never the interrupt
// - device-alive reads one once settled after reset or wake
`default_nettype none
module epwc_ctrl
   import epwc_pkg::*;
#(
   parameter int PULSE_CYCLES  = PULSE_CYC,
   parameter int SETTLE_CYCLES = SETTLE_CYC
) (
   // clock and reset
   input  wire logic          pclk,
   input  wire logic          presetn,
   // apb slave
   input  wire epwc_apb_req_t apb_req,
   output var  epwc_apb_rsp_t apb_rsp,
   // wake event sources, held until cleared at source
   input  wire logic          lan_wake_src,
   input  wire logic          energy_wake_src,
   // wake pin, interrupt, transceiver reset, status
   output var  epwc_pin_t     wake_event_output,
   output logic               wake_event_interrupt,
   output logic               transceiver_reset,
   output logic [1:0]         power_state_field,
   output logic               device_alive
);

   typedef struct packed {
      epwc_pstate_t        pstate;
      logic [SETTLE_W-1:0] settle_cnt;
      logic                read_seen;
      logic                xrst;
      logic [XRST_W-1:0]   xrst_cnt;
      logic                lan_en;
      logic                nrg_en;
      logic                drv_type;
      logic                pulse_sel;
      logic                pol;
      logic                out_en;
      logic [1:0]          cause;
      logic [PULSE_W-1:0]  pulse_cnt;
      epwc_apb_rsp_t       rsp;
      epwc_pin_t           pin;
      logic                irq;
      logic [1:0]          mode;
      logic                alive_flag;
   } epwc_state_t;

   localparam logic [SETTLE_W-1:0] SETTLE_LOAD = SETTLE_W'(SETTLE_CYCLES - 1);
   localparam logic [XRST_W-1:0]   XRST_LOAD   = XRST_W'(XRST_CYC - 1);
   localparam logic [PULSE_W-1:0]  PULSE_LOAD  = PULSE_W'(PULSE_CYCLES);
   localparam epwc_state_t         ST_RESET    = '{
      pstate: ST_SETTLE, settle_cnt: SETTLE_LOAD, read_seen: 1'b0, xrst: 1'b0,
      xrst_cnt: '0, lan_en: 1'b0, nrg_en: 1'b0, drv_type: 1'b0, pulse_sel: 1'b0,
      pol: 1'b0, out_en: 1'b0, cause: 2'h0, pulse_cnt: '0,
      rsp: '{prdata: WORD_ZERO, pready: 1'b0, pslverr: 1'b0},
      pin: '{out: 1'b0, oe: 1'b0}, irq: 1'b0, mode: MODE_FULL, alive_flag: 1'b0};

   epwc_state_t q;
   epwc_state_t d;

   logic        setup;
   logic        acc_wr;
   logic        acc_rd;
   logic        hit_pc;
   logic        hit_bt;
   logic        alive;
   logic        low_pwr;
   logic        wr_ok;
   logic [1:0]  mode_now;
   logic [1:0]  cause_set;
   logic [1:0]  cause_clr;
   logic [1:0]  srcs;
   logic [1:0]  en_vec;
   logic        active;
   logic [31:0] pc_word;

   assign setup    = apb_req.psel & ~apb_req.penable;
   assign acc_wr   = apb_req.psel & apb_req.penable & q.rsp.pready & apb_req.pwrite;
   assign acc_rd   = apb_req.psel & apb_req.penable & q.rsp.pready & ~apb_req.pwrite;
   assign hit_pc   = apb_req.paddr == OFS_PWR_CTRL;
   assign hit_bt   = apb_req.paddr == OFS_BYTE_TEST;
   assign alive    = q.pstate == ST_FULL;
   assign low_pwr  = (q.pstate == ST_FRAME) | (q.pstate == ST_ENERGY);
   assign wr_ok    = acc_wr & hit_pc & alive & q.read_seen;
   assign srcs     = {lan_wake_src, energy_wake_src};
   assign en_vec   = {q.lan_en, q.nrg_en};

   always_comb begin
      mode_now = MODE_FULL;
      if (q.pstate == ST_FRAME) begin
         mode_now = MODE_FRAME;
      end else if (q.pstate == ST_ENERGY) begin
         mode_now = MODE_ENERGY;
      end
   end

   always_comb begin
      pc_word                        = WORD_ZERO;
      pc_word[MODE_MSB:MODE_LSB]     = mode_now;
      pc_word[XRST_BIT]              = q.xrst;
      pc_word[LAN_EN_BIT]            = q.lan_en;
      pc_word[NRG_EN_BIT]            = q.nrg_en;
      pc_word[DRV_TYPE_BIT]          = q.drv_type;
      pc_word[CAUSE_MSB:CAUSE_LSB]   = q.cause;
      pc_word[PULSE_SEL_BIT]         = q.pulse_sel;
      pc_word[POL_BIT]               = q.pol;
      pc_word[OUT_EN_BIT]            = q.out_en;
      pc_word[ALIVE_BIT]             = alive;
   end

   always_comb begin
      d             = q;
      d.rsp.pready  = 1'b0;
      d.rsp.pslverr = 1'b0;
      cause_set     = srcs & en_vec;
      cause_clr     = 2'h0;
      active        = 1'b0;

      // apb answer, ready in the first access cycle
      if (setup) begin
         d.rsp.pready  = 1'b1;
         d.rsp.pslverr = ~(hit_pc | hit_bt);
         if (hit_pc) begin
            d.rsp.prdata = pc_word;
         end else if (hit_bt & alive) begin
            d.rsp.prdata = BYTE_TEST_VAL;
         end else begin
            d.rsp.prdata = WORD_ZERO;
         end
      end
      if (acc_rd) begin
         d.read_seen = 1'b1;
      end

      // power state sequence
      case (q.pstate)
         ST_SETTLE: begin
            if (q.settle_cnt == '0) begin
               d.pstate = ST_FULL;
            end else begin
               d.settle_cnt = q.settle_cnt - 1'b1;
            end
         end
         ST_FULL: begin
            if (wr_ok) begin
               if (apb_req.pwdata[MODE_MSB:MODE_LSB] == MODE_FRAME) begin
                  d.pstate = ST_FRAME;
               end else if (apb_req.pwdata[MODE_MSB:MODE_LSB] == MODE_ENERGY) begin
                  d.pstate = ST_ENERGY;
               end
            end
         end
         ST_FRAME, ST_ENERGY: begin
            if (acc_wr & hit_bt) begin
               d.pstate     = ST_SETTLE;
               d.settle_cnt = SETTLE_LOAD;
               d.read_seen  = 1'b0;
            end
         end
         default: begin
            d.pstate = ST_SETTLE;
         end
      endcase

      // control bits
      if (wr_ok) begin
         d.lan_en    = apb_req.pwdata[LAN_EN_BIT];
         d.nrg_en    = apb_req.pwdata[NRG_EN_BIT];
         d.drv_type  = apb_req.pwdata[DRV_TYPE_BIT];
         d.pulse_sel = apb_req.pwdata[PULSE_SEL_BIT];
         d.pol       = apb_req.pwdata[POL_BIT];
         d.out_en    = apb_req.pwdata[OUT_EN_BIT];
         cause_clr   = apb_req.pwdata[CAUSE_MSB:CAUSE_LSB];
      end

      // transceiver reset timer
      if (q.xrst) begin
         if (q.xrst_cnt == '0) begin
            d.xrst = 1'b0;
         end else begin
            d.xrst_cnt = q.xrst_cnt - 1'b1;
         end
      end else if (wr_ok & apb_req.pwdata[XRST_BIT]) begin
         d.xrst     = 1'b1;
         d.xrst_cnt = XRST_LOAD;
      end

      // wake cause, set wins over clear
      d.cause = cause_set | (q.cause & ~(cause_clr & ~srcs));

      // pulse timer on a new event
      if (|(cause_set & ~q.cause) & q.pulse_sel) begin
         d.pulse_cnt = PULSE_LOAD;
      end else if (q.pulse_cnt != '0) begin
         d.pulse_cnt = q.pulse_cnt - 1'b1;
      end

      // wake pin and interrupt
      if (q.pulse_sel) begin
         active = q.out_en & (q.pulse_cnt != '0);
      end else begin
         active = q.out_en & |(q.cause & en_vec);
      end
      if (q.drv_type) begin
         d.pin.oe  = 1'b1;
         d.pin.out = q.pol ? active : ~active;
      end else begin
         d.pin.oe  = active;
         d.pin.out = 1'b0;
      end
      d.irq  = |(q.cause & en_vec);
      d.mode = mode_now;
      d.alive_flag = d.pstate == ST_FULL;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= ST_RESET;
      end else begin
         q <= d;
      end
   end

   assign apb_rsp              = q.rsp;
   assign wake_event_output    = q.pin;
   assign wake_event_interrupt = q.irq;
   assign transceiver_reset    = q.xrst;
   assign power_state_field    = q.mode;
   assign device_alive         = q.alive_flag;

   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   logic [XRST_W:0] xrst_len;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xrst_len <= '0;
      end else if (q.xrst) begin
         xrst_len <= xrst_len + 1'b1;
      end else begin
         xrst_len <= '0;
      end
   end

   xrst_hold_a: assert property ($fell(q.xrst) |-> xrst_len == (XRST_W + 1)'(XRST_CYC))
      else $error("transceiver reset held for wrong length");
   xrst_wr_ign_a: assert property ((q.xrst && acc_wr && hit_pc && q.xrst_cnt != '0)
      |=> q.xrst_cnt == $past(q.xrst_cnt) - 1'b1)
      else $error("transceiver reset write not ignored");
   write_gate_a: assert property ((acc_wr && hit_pc && !q.read_seen)
      |=> $stable(q.lan_en) && $stable(q.out_en) && $stable(q.pol))
      else $error("write took effect before a read");
   byte_wake_a: assert property ((acc_wr && hit_bt && low_pwr)
      |=> q.pstate == ST_SETTLE ##SETTLE_CYCLES q.pstate == ST_FULL)
      else $error("byte test write did not wake");
   mode_frame_a: assert property ((wr_ok && apb_req.pwdata[MODE_MSB:MODE_LSB] == MODE_FRAME)
      |=> q.pstate == ST_FRAME ##1 power_state_field == MODE_FRAME)
      else $error("frame wake state not entered");
   cause_hold_a: assert property ((q.cause[1] && (lan_wake_src || !alive))
      |=> q.cause[1])
      else $error("wake cause cleared too early");
   cause_clr_a: assert property ((wr_ok && apb_req.pwdata[CAUSE_MSB] && !lan_wake_src
      && !(lan_wake_src && q.lan_en)) |=> !q.cause[1])
      else $error("wake cause not cleared");
   irq_en_a: assert property ((|(q.cause & en_vec) && !q.out_en) |=> q.irq)
      else $error("interrupt gated by pin enable");
   od_pin_a: assert property (!q.drv_type |=> !q.pin.out)
      else $error("open drain pin driven high");
   pol_high_a: assert property ((q.drv_type && q.pol && q.out_en && !q.pulse_sel
      && |(q.cause & en_vec)) |=> q.pin.out && q.pin.oe)
      else $error("push-pull active high pin not asserted");
   pulse_a: assert property (($rose(q.cause[1]) && q.lan_en && q.pulse_sel && q.out_en)
      |-> q.pulse_cnt == PULSE_LOAD ##1 active)
      else $error("wake pulse not started");
   pc_read_a: assert property ((setup && hit_pc)
      |=> apb_rsp.pready && apb_rsp.prdata[ALIVE_BIT] == $past(alive))
      else $error("power control read wrong");
   mode_nrg_a: assert property ((wr_ok && apb_req.pwdata[MODE_MSB:MODE_LSB] == MODE_ENERGY)
      |=> q.pstate == ST_ENERGY ##1 power_state_field == MODE_ENERGY)
      else $error("energy wake state not entered");
   mode_rsvd_a: assert property ((wr_ok && apb_req.pwdata[MODE_MSB:MODE_LSB] != MODE_FRAME
      && apb_req.pwdata[MODE_MSB:MODE_LSB] != MODE_ENERGY) |=> q.pstate == ST_FULL)
      else $error("reserved or full mode left the full state");
   low_hold_a: assert property ((low_pwr && !(acc_wr && hit_bt)) |=> $stable(q.pstate))
      else $error("reduced power state left without wake write");
   read_seen_a: assert property (acc_rd |=> q.read_seen)
      else $error("completed read not recorded");
   xrst_set_a: assert property ((wr_ok && apb_req.pwdata[XRST_BIT] && !q.xrst)
      |=> transceiver_reset)
      else $error("transceiver reset not started");
   xrst_end_a: assert property ((q.xrst && q.xrst_cnt == '0) |=> !transceiver_reset)
      else $error("transceiver reset did not self-clear");
   cause_alive_a: assert property ((q.cause[0] && !alive) |=> q.cause[0])
      else $error("energy cause cleared while not alive");
   nrg_hold_a: assert property ((q.cause[0] && energy_wake_src) |=> q.cause[0])
      else $error("energy cause cleared with source high");
   lan_pin_a: assert property ((lan_wake_src && q.lan_en && q.out_en && !q.pulse_sel
      && !q.drv_type && !wr_ok) |=> ##1 wake_event_output.oe)
      else $error("open drain pin not driven on lan wake");
   nrg_pin_a: assert property ((energy_wake_src && q.nrg_en && q.out_en && !q.pulse_sel
      && q.drv_type && q.pol && !wr_ok)
      |=> ##1 (wake_event_output.oe && wake_event_output.out))
      else $error("push-pull pin not driven on energy wake");
   lan_irq_a: assert property ((lan_wake_src && q.lan_en && !wr_ok)
      |=> ##1 wake_event_interrupt)
      else $error("interrupt not raised on lan wake");
   nrg_irq_a: assert property ((energy_wake_src && q.nrg_en && !wr_ok)
      |=> ##1 wake_event_interrupt)
      else $error("interrupt not raised on energy wake");
   pol_low_a: assert property ((q.drv_type && !q.pol && active)
      |=> wake_event_output.oe && !wake_event_output.out)
      else $error("push-pull active low pin not asserted");
   pin_en_a: assert property ((!q.out_en && !q.drv_type) |=> !wake_event_output.oe)
      else $error("open drain pin driven while disabled");
   settle_low_a: assert property ((q.pstate == ST_SETTLE) |-> !device_alive)
      else $error("device alive while settling");
   settle_done_a: assert property ((q.pstate == ST_SETTLE && q.settle_cnt == '0)
      |=> device_alive)
      else $error("device alive not raised after settling");

   wake_cov_c: cover property (low_pwr ##1 (acc_wr && hit_bt) ##[1:40] alive);
   xrst_cov_c: cover property ($fell(q.xrst));
   pulse_cov_c: cover property ($fell(q.pulse_cnt != '0));
   both_cov_c: cover property (q.cause == 2'h3);
   nrg_cov_c: cover property (power_state_field == MODE_ENERGY);

endmodule : epwc_ctrl
`default_nettype wire

/* File: core/epwc_pkg.sv */
`default_nettype none
package epwc_pkg;
   // register map
   localparam int                ADDR_W          = 12;
   localparam logic [ADDR_W-1:0] OFS_PWR_CTRL    = 12'h084;
   localparam logic [ADDR_W-1:0] OFS_BYTE_TEST   = 12'h0A0;
   // arbitrary read-back pattern of the byte test register
   localparam logic [31:0]       BYTE_TEST_VAL   = 32'h5A5A_0F0F;
   localparam logic [31:0]       WORD_ZERO       = 32'h0000_0000;
   // power_wake_control field positions
   localparam int                MODE_LSB        = 12;
   localparam int                MODE_MSB        = 13;
   localparam int                XRST_BIT        = 10;
   localparam int                LAN_EN_BIT      = 9;
   localparam int                NRG_EN_BIT      = 8;
   localparam int                DRV_TYPE_BIT    = 6;
   localparam int                CAUSE_LSB       = 4;
   localparam int                CAUSE_MSB       = 5;
   localparam int                PULSE_SEL_BIT   = 3;
   localparam int                POL_BIT         = 2;
   localparam int                OUT_EN_BIT      = 1;
   localparam int                ALIVE_BIT       = 0;
   // power state encodings
   localparam logic [1:0]        MODE_FULL       = 2'h0;
   localparam logic [1:0]        MODE_FRAME      = 2'h1;
   localparam logic [1:0]        MODE_ENERGY     = 2'h2;
   // timing
   localparam int                CLK_PERIOD_NS   = 25;
   localparam int                XRST_US         = 100;
   localparam int                XRST_CYC        = (XRST_US * 1000 + CLK_PERIOD_NS - 1)
                                                   / CLK_PERIOD_NS;
   localparam int                XRST_W          = 12;
   localparam int                PULSE_MS        = 50;
   localparam int                PULSE_CYC       = (PULSE_MS * 1000000) / CLK_PERIOD_NS;
   localparam int                PULSE_W         = 21;
   localparam int                SETTLE_CYC      = 16;
   localparam int                SETTLE_W        = 8;

   typedef enum logic [1:0] {ST_SETTLE, ST_FULL, ST_FRAME, ST_ENERGY} epwc_pstate_t;

   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0]       pwdata;
   } epwc_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } epwc_apb_rsp_t;

   typedef struct packed {
      logic out;
      logic oe;
   } epwc_pin_t;
endpackage : epwc_pkg
`default_nettype wire
